// File: ssc_delay.sv
`timescale 1ns/1ps
module ssc_delay
    import ssc_pkg::*;
#(
    parameter int WIDTH = 11
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic busy
);
    logic [WIDTH-1:0] cnt_r;
    initial begin
        if (WIDTH < 2) $error("ssc_delay width too small");
    end
    // down-counter on the system clock
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
    assign busy = load || (cnt_r != '0);
endmodule

// File: ssc_pkg.sv
package ssc_pkg;
    localparam logic [11:0] SSC_CTRL_OFS = 12'h050;
    localparam logic [11:0] SSC_IRQ_STATUS_OFS = 12'h054;
    localparam logic [11:0] SSC_IRQ_MASK_OFS = 12'h058;
    localparam int SSC_LVL_LSB = 4;
    localparam int SSC_RSTEN_BIT = 3;
    localparam int SSC_ACTIVE_BIT = 2;
    localparam int SSC_CMP_BIT = 1;
    localparam int SSC_FLAG_BIT = 0;
    localparam logic [7:0] SSC_CTRL_RESET = 8'h00;
    localparam logic [3:0] SSC_LVL_OFF = 4'h0;
    localparam logic [3:0] SSC_LVL_EXT = 4'hF;
    localparam logic [2:0] SSC_IRQ_RESET = 3'h0;
    localparam int SSC_CLK_HZ = 20000000;
    localparam int SSC_TON_US = 50;
    localparam int SSC_TSETTLE_US = 12;
    localparam int SSC_TON_CYC = (SSC_TON_US * (SSC_CLK_HZ / 1000000));
    localparam int SSC_TSETTLE_CYC = (SSC_TSETTLE_US * (SSC_CLK_HZ / 1000000));

    typedef enum logic [1:0] {
        SSC_OFF = 2'b00,
        SSC_SETTLE = 2'b01,
        SSC_MON = 2'b11
    } ssc_state_type;

    typedef struct packed {
        logic [3:0] level;
        logic rst_en;
    } ssc_cfg_type;
endpackage

// File: ssc_properties.sv
`timescale 1ns/1ps
module ssc_properties
    import ssc_pkg::*;
#(
    parameter int TON_CYC = SSC_TON_CYC,
    parameter int TSETTLE_CYC = SSC_TSETTLE_CYC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] threshold_select,
    input wire logic ext_select,
    input wire logic monitor_enable,
    input wire logic power_on_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // two cycles of slack, since the exact end of settling is the design's
    logic [15:0] quiet_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            quiet_r <= 16'h0000;
        end else if ($rose(monitor_enable)) begin
            quiet_r <= 16'(TON_CYC - 2);
        end else if ($changed(threshold_select) && monitor_enable && $past(monitor_enable)) begin
            quiet_r <= 16'(TSETTLE_CYC - 2);
        end else if (quiet_r != 16'h0000) begin
            quiet_r <= quiet_r - 16'h0001;
        end
    end
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_ctrl_write;
        psel && penable && pwrite && (paddr == SSC_CTRL_OFS);
    endsequence
    a_ready_one_wait: assert property (s_access |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("lone error");
    a_enable_level: assert property (monitor_enable == (threshold_select != SSC_LVL_OFF))
        else $error("enable wrong");
    a_ext_route: assert property (ext_select == (threshold_select == SSC_LVL_EXT))
        else $error("ext wrong");
    a_reset_needs_on: assert property (power_on_reset |-> monitor_enable)
        else $error("reset while off");
    a_settle_quiet: assert property (quiet_r != 16'h0000 |-> !power_on_reset)
        else $error("reset in settling");
    a_level_by_write: assert property ($changed(threshold_select) |-> $past(rst) ||
        $past(psel && penable && pwrite && (paddr == SSC_CTRL_OFS))) else $error("level moved");
    c_ctrl_write: cover property (s_ctrl_write);
endmodule
bind ssc_top ssc_properties #(.TON_CYC(TON_CYC), .TSETTLE_CYC(TSETTLE_CYC)) chk_u (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .threshold_select(threshold_select),
    .ext_select(ext_select), .monitor_enable(monitor_enable), .power_on_reset(power_on_reset));

// File: ssc_supply_model.sv
`timescale 1ns/1ps
module ssc_supply_model
    import ssc_pkg::*;
(
    input wire logic [3:0] threshold_select,
    input wire logic ext_select,
    input wire logic monitor_enable,
    input wire logic [3:0] supply_code,
    input wire logic ext_low,
    output logic cmp_low
);
    // supply code n sits at threshold n, so thresholds rise with the code
    always_comb begin
        if (!monitor_enable) begin
            cmp_low = 1'b0;
        end else if (ext_select) begin
            cmp_low = ext_low;
        end else begin
            cmp_low = (supply_code < threshold_select);
        end
    end
endmodule

// File: ssc_sync.sv
`timescale 1ns/1ps
module ssc_sync
    import ssc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta_r;
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// File: ssc_top.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// What this block does
// - level zero disables, nonzero enables monitoring
// - all-ones level selects external input
// - level bits 7:4, 14 rising thresholds
// - low voltage sets the flag
// - reset enable bit turns flag into reset
// - flag latched until software clears it
// - clear during low condition sets again
// - active bit read-only, reports monitoring state
// - off to on waits about 50 us
// - level change waits about 12 us
// - no flag set, reset or active during settling; a held flag stays
// - comparator bit shows live comparator output
// - power-on reset clears control register
module ssc_top
    import ssc_pkg::*;
#(
    parameter int TON_CYC = SSC_TON_CYC,
    parameter int TSETTLE_CYC = SSC_TSETTLE_CYC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_low,
    output logic [3:0] threshold_select,
    output logic ext_select,
    output logic monitor_enable,
    output logic power_on_reset,
    output logic irq
);
    localparam int DW = 11;

    initial begin
        if (TON_CYC < 1 || TON_CYC >= (1 << DW)) $error("TON_CYC out of range");
        if (TSETTLE_CYC < 1 || TSETTLE_CYC > TON_CYC) $error("TSETTLE_CYC out of range");
    end

    ssc_cfg_type cfg_r;
    logic flag_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_mask_r;
    ssc_state_type state_r;
    logic cmp_s;
    logic cmp_prev_r;
    logic act_prev_r;
    logic dly_load;
    logic [DW-1:0] dly_count;
    logic dly_busy;
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic wr_ctrl;
    logic [3:0] new_level;
    logic active;
    logic low_event;
    logic [2:0] irq_ev;
    ssc_cfg_type cfg_nxt;
    ssc_state_type state_nxt;
    logic flag_nxt;
    logic [2:0] irq_status_nxt;
    logic sel_ctrl;
    logic sel_status;
    logic sel_mask;
    logic ev_flag_rise;
    logic ev_cmp_change;
    logic ev_act_rise;

    function automatic logic [31:0] ctrl_word(input ssc_cfg_type c, input logic act,
                                              input logic cmp, input logic fg);
        ctrl_word = {24'h000000, c.level, c.rst_en, act, cmp, fg};
    endfunction

    // one aligned word per register, so the full byte address must match
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // strobes act only at the first access edge, while pready is still low, so a
    // write-one-to-clear cannot strike twice and wipe an event caught in between
    assign wr_acc = psel && penable && pwrite && !pready;
    assign rd_acc = psel && penable && !pwrite && !pready;
    assign sel_ctrl = reg_hit(paddr, SSC_CTRL_OFS);
    assign sel_status = reg_hit(paddr, SSC_IRQ_STATUS_OFS);
    assign sel_mask = reg_hit(paddr, SSC_IRQ_MASK_OFS);
    assign addr_ok = sel_ctrl || sel_status || sel_mask;
    assign wr_ctrl = wr_acc && sel_ctrl;
    assign new_level = pwdata[SSC_LVL_LSB+3:SSC_LVL_LSB];

    ssc_sync u_sync (
        .clock(clock),
        .rst(rst),
        .din(cmp_low),
        .dout(cmp_s)
    );

    // settling delay choice on a level change
    always_comb begin
        dly_load = 1'b0;
        dly_count = '0;
        if (wr_ctrl && new_level != SSC_LVL_OFF && new_level != cfg_r.level) begin
            dly_load = 1'b1;
            if (cfg_r.level == SSC_LVL_OFF) begin
                dly_count = DW'(TON_CYC);
            end else begin
                dly_count = DW'(TSETTLE_CYC);
            end
        end
    end

    ssc_delay #(
        .WIDTH(DW)
    ) u_delay (
        .clock(clock),
        .rst(rst),
        .load(dly_load),
        .count(dly_count),
        .busy(dly_busy)
    );

    // only level and reset enable are stored in cfg_r; flag is held in flag_r, active and comparator are live status
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_ctrl) begin
            cfg_nxt.level = new_level;
            cfg_nxt.rst_en = pwdata[SSC_RSTEN_BIT];
        end
    end

    // the reset output feeds back into rst, so the control register clears itself
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_r <= ssc_cfg_type'(SSC_CTRL_RESET[7:3]);
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    // writing zero turns the monitor off at once, even in the middle of settling
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SSC_OFF: begin
                if (dly_load) begin
                    state_nxt = SSC_SETTLE;
                end
            end
            SSC_SETTLE: begin
                if (wr_ctrl && new_level == SSC_LVL_OFF) begin
                    state_nxt = SSC_OFF;
                end else if (!dly_busy) begin
                    state_nxt = SSC_MON;
                end
            end
            SSC_MON: begin
                if (wr_ctrl && new_level == SSC_LVL_OFF) begin
                    state_nxt = SSC_OFF;
                end else if (dly_load) begin
                    state_nxt = SSC_SETTLE;
                end
            end
            default: begin
                state_nxt = SSC_OFF;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= SSC_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign active = (state_r == SSC_MON);
    assign low_event = active && cmp_s;

    // set beats the software clear, so a lasting low re-flags at once
    always_comb begin
        flag_nxt = flag_r;
        if (low_event) begin
            flag_nxt = 1'b1;
        end else if (wr_ctrl && !pwdata[SSC_FLAG_BIT]) begin
            flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            power_on_reset <= 1'b0;
        end else begin
            power_on_reset <= flag_r && cfg_r.rst_en && active;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            threshold_select <= SSC_LVL_OFF;
            ext_select <= 1'b0;
            monitor_enable <= 1'b0;
        end else begin
            threshold_select <= cfg_r.level;
            ext_select <= (cfg_r.level == SSC_LVL_EXT);
            monitor_enable <= (cfg_r.level != SSC_LVL_OFF);
        end
    end

    // events: 0 flag rise, 1 comparator change, 2 active rise
    always_ff @(posedge clock) begin
        if (rst) begin
            cmp_prev_r <= 1'b0;
            act_prev_r <= 1'b0;
        end else begin
            cmp_prev_r <= cmp_s;
            act_prev_r <= active;
        end
    end
    assign ev_flag_rise = low_event && !flag_r;
    assign ev_cmp_change = cmp_s != cmp_prev_r;
    assign ev_act_rise = active && !act_prev_r;
    assign irq_ev = {ev_act_rise, ev_cmp_change, ev_flag_rise};

    // an event in the cycle of its own clear keeps its status bit set
    always_comb begin
        irq_status_nxt = irq_status_r | irq_ev;
        if (wr_acc && sel_status) begin
            irq_status_nxt = (irq_status_r & ~pwdata[2:0]) | irq_ev;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_status_r <= SSC_IRQ_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_mask_r <= SSC_IRQ_RESET;
        end else if (wr_acc && sel_mask) begin
            irq_mask_r <= pwdata[2:0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // apb: one wait state so read data comes from a flop
    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // an unmapped offset answers with an error, reads zero and ignores writes
    always_ff @(posedge clock) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (rd_acc) begin
            if (sel_ctrl) begin
                prdata <= ctrl_word(cfg_r, active, cmp_s, flag_r);
            end else if (sel_status) begin
                prdata <= {29'h00000000, irq_status_r};
            end else if (sel_mask) begin
                prdata <= {29'h00000000, irq_mask_r};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule

// File: ssc_top_test.sv
`timescale 1ns/1ps
module ssc_top_test;
    import ssc_pkg::*;
    logic clock = 1'b0, bench_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [3:0] supply_code = 4'hF, threshold_select;
    logic ext_low = 1'b0, err, pready, pslverr, cmp_low, ext_select, monitor_enable;
    logic power_on_reset, irq;
    int mismatches = 0, cmp_count = 0;
    // the reset request loops back, as the device reset would
    wire dut_rst = bench_rst | power_on_reset;
    always #25 clock = ~clock;
    ssc_top #(.TON_CYC(8), .TSETTLE_CYC(4)) dut_u (.clock(clock), .rst(dut_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_low(cmp_low), .threshold_select(threshold_select),
        .ext_select(ext_select), .monitor_enable(monitor_enable),
        .power_on_reset(power_on_reset), .irq(irq));
    ssc_supply_model model_u (.threshold_select(threshold_select), .ext_select(ext_select),
        .monitor_enable(monitor_enable), .supply_code(supply_code), .ext_low(ext_low),
        .cmp_low(cmp_low));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: no ready", $time);
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_active(input int lim);
        int n;
        n = 0;
        do begin
            apb(1'b0, SSC_CTRL_OFS, 32'h0);
            n++;
        end while (rd[2] !== 1'b1 && n < lim);
        chk(rd[2], 32'h1);
        if (rd[2] !== 1'b1) begin
            print_verdict();
        end
    endtask
    task automatic t_reset();
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, SSC_IRQ_MASK_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_levels();
        // the active bit is written one each time and must never enable
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, SSC_CTRL_OFS, {24'h0, 4'(i), 4'h4});
            @(negedge clock);
            chk({threshold_select, ext_select, monitor_enable}, {4'(i), i == 15, i != 0});
            apb(1'b0, SSC_CTRL_OFS, 32'h0);
            chk(rd & 32'hF0, {24'h0, 4'(i), 4'h0});
        end
        apb(1'b1, SSC_CTRL_OFS, 32'h0);
        $display("test levels done");
    endtask
    task automatic t_settle();
        supply_code <= 4'h2;
        apb(1'b1, SSC_CTRL_OFS, 32'h30);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd & 32'h5, 32'h0);
        wait_active(10);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd & 32'h7, 32'h7);
        apb(1'b1, SSC_CTRL_OFS, 32'h51);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd & 32'h4, 32'h0);
        wait_active(4);
        $display("test settle done");
    endtask
    task automatic t_latch();
        supply_code <= 4'hF;
        repeat (4) @(posedge clock);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk({rd[1:0], power_on_reset}, 32'h2);
        apb(1'b1, SSC_CTRL_OFS, 32'h50);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd & 32'h3, 32'h0);
        supply_code <= 4'h2;
        repeat (4) @(posedge clock);
        apb(1'b1, SSC_CTRL_OFS, 32'h50);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd & 32'h3, 32'h3);
        $display("test latch done");
    endtask
    task automatic t_irq();
        apb(1'b1, SSC_IRQ_MASK_OFS, 32'h1);
        @(negedge clock);
        chk(irq, 32'h1);
        apb(1'b1, SSC_IRQ_STATUS_OFS, 32'h7);
        @(negedge clock);
        chk(irq, 32'h0);
        apb(1'b1, SSC_IRQ_MASK_OFS, 32'h0);
        $display("test irq done");
    endtask
    task automatic t_ext();
        // external channel: the held flag outlives both settling and the low
        apb(1'b1, SSC_CTRL_OFS, 32'hF0);
        wait_active(4);
        chk(rd & 32'h3, 32'h1);
        apb(1'b1, SSC_CTRL_OFS, 32'hF0);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd & 32'h3, 32'h0);
        ext_low <= 1'b1;
        repeat (4) @(posedge clock);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk(rd & 32'h3, 32'h3);
        $display("test ext done");
    endtask
    task automatic t_por();
        int n;
        apb(1'b1, SSC_CTRL_OFS, 32'h58);
        n = 0;
        while (power_on_reset !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk(power_on_reset, 32'h1);
        if (power_on_reset !== 1'b1) begin
            print_verdict();
        end
        repeat (3) @(posedge clock);
        apb(1'b0, SSC_CTRL_OFS, 32'h0);
        chk({rd[30:0], monitor_enable}, 32'h0);
        $display("test por done");
    endtask
    initial begin
        repeat (4) @(posedge clock);
        bench_rst <= 1'b0;
        t_reset();
        t_levels();
        t_settle();
        t_latch();
        t_irq();
        t_ext();
        t_por();
        print_verdict();
    end
endmodule
